// >>> lfcb_coeff_bank.v
`timescale 1ns/1ps
`default_nettype none
`include "lfcb_defs.vh"

module lfcb_coeff_bank (
  input  wire        core_clk,                     // device clock, 50 MHz
  input  wire        rst,                          // sync reset, active high
  input  wire [7:0]  reg_page,                     // selected register page
  input  wire [6:0]  reg_addr,                     // register address in page
  input  wire        reg_wr,                       // write strobe, one cycle
  input  wire        reg_rd,                       // read strobe, one cycle
  input  wire [7:0]  reg_wdata,                    // write data byte
  output wire        reg_sel,                      // address is in this bank
  output wire [7:0]  reg_rdata,                    // read data, registered
  output wire        reg_ack,                      // access answered pulse
  output wire [15:0] coef_effects_denominator_two, // signed coefficient
  output wire [15:0] coef_effects_denominator_four,// signed coefficient
  output wire [15:0] coef_effects_denominator_five,// signed coefficient
  output wire [15:0] coef_deemph_numerator_zero,   // signed coefficient
  output wire [15:0] coef_deemph_numerator_one     // signed coefficient
);

  // page check; other pages never reach the store
  function lfcb_page_ok;
    input [7:0] page;
    begin
      lfcb_page_ok = (page == `LFCB_PAGE);
    end
  endfunction

  // address range of the bank inside its page
  function lfcb_addr_in_bank;
    input [6:0] addr;
    begin
      lfcb_addr_in_bank = (addr >= `LFCB_OFS_FIRST) &&
                          (addr <= `LFCB_OFS_LAST);
    end
  endfunction

  // page and address decode, shared by the read and write paths
  function lfcb_hit;
    input [7:0] page;
    input [6:0] addr;
    begin
      lfcb_hit = lfcb_page_ok(page) && lfcb_addr_in_bank(addr);
    end
  endfunction

  // byte index inside the bank, valid only when lfcb_hit is true
  function [3:0] lfcb_index;
    input [6:0] addr;
    reg   [6:0] diff;
    begin
      diff       = addr - `LFCB_OFS_FIRST;
      lfcb_index = diff[3:0];
    end
  endfunction

  // reset byte for each bank slot
  function [7:0] lfcb_reset_byte;
    input [3:0] idx;
    begin
      case (idx)
        4'h0:    lfcb_reset_byte = `LFCB_RST_EFF_DEN2_HIGH;
        4'h1:    lfcb_reset_byte = `LFCB_RST_EFF_DEN2_LOW;
        4'h2:    lfcb_reset_byte = `LFCB_RST_EFF_DEN4_HIGH;
        4'h3:    lfcb_reset_byte = `LFCB_RST_EFF_DEN4_LOW;
        4'h4:    lfcb_reset_byte = `LFCB_RST_EFF_DEN5_HIGH;
        4'h5:    lfcb_reset_byte = `LFCB_RST_EFF_DEN5_LOW;
        4'h6:    lfcb_reset_byte = `LFCB_RST_DEEMPH_NUM0_HIGH;
        4'h7:    lfcb_reset_byte = `LFCB_RST_DEEMPH_NUM0_LOW;
        4'h8:    lfcb_reset_byte = `LFCB_RST_DEEMPH_NUM1_HIGH;
        4'h9:    lfcb_reset_byte = `LFCB_RST_DEEMPH_NUM1_LOW;
        default: lfcb_reset_byte = 8'h00;
      endcase
    end
  endfunction

  // coefficient assembly, high byte above low byte
  function [`LFCB_COEF_W-1:0] lfcb_join;
    input [`LFCB_REG_W-1:0] high_byte;
    input [`LFCB_REG_W-1:0] low_byte;
    begin
      lfcb_join = {high_byte, low_byte};
    end
  endfunction

  // one-hot write select; a clear mask leaves every byte as it was, so
  // a write never spills into the partner byte of its coefficient
  function [`LFCB_NUM_REGS-1:0] lfcb_write_mask;
    input [3:0] slot;
    input       en;
    integer     k;
    begin
      lfcb_write_mask = {`LFCB_NUM_REGS{1'b0}};
      for (k = 0; k < `LFCB_NUM_REGS; k = k + 1) begin
        if (en && (slot == k[3:0])) begin
          lfcb_write_mask[k] = 1'b1;
        end
      end
    end
  endfunction

  // byte store and its next value; every flop reloads on every edge
  reg  [7:0]  coef_q [0:`LFCB_NUM_REGS-1];
  reg  [7:0]  coef_d [0:`LFCB_NUM_REGS-1];
  // answer registers for the read data and the access pulse
  reg  [7:0]  rdata_q;
  reg  [7:0]  rdata_d;
  reg         ack_q;
  reg         ack_d;
  // decode results
  wire        hit;
  wire [3:0]  idx;
  wire        wr_hit;
  wire        rd_hit;
  wire [`LFCB_NUM_REGS-1:0] wr_mask;
  integer     i;
  integer     j;

  // named byte views of the store, one pair per coefficient
  wire [7:0]  den2_hi;
  wire [7:0]  den2_lo;
  wire [7:0]  den4_hi;
  wire [7:0]  den4_lo;
  wire [7:0]  den5_hi;
  wire [7:0]  den5_lo;
  wire [7:0]  num0_hi;
  wire [7:0]  num0_lo;
  wire [7:0]  num1_hi;
  wire [7:0]  num1_lo;

  // one decoder serves both strobes
  assign hit     = lfcb_hit(reg_page, reg_addr);
  assign idx     = lfcb_index(reg_addr);
  assign reg_sel = hit;
  assign wr_hit  = reg_wr & hit;
  assign rd_hit  = reg_rd & hit;
  assign wr_mask = lfcb_write_mask(idx, wr_hit);

  // next byte values: only the masked byte takes the write data, the
  // partner half of a coefficient keeps its value; software updating a
  // whole coefficient sees a mixed value between its two writes
  always @* begin
    for (j = 0; j < `LFCB_NUM_REGS; j = j + 1) begin
      if (wr_mask[j]) begin
        coef_d[j] = reg_wdata;
      end else begin
        coef_d[j] = coef_q[j];
      end
    end
  end

  // byte store, loaded with the reset bytes while rst is high
  always @(posedge core_clk) begin
    if (rst) begin
      for (i = 0; i < `LFCB_NUM_REGS; i = i + 1) begin
        coef_q[i] <= lfcb_reset_byte(i[3:0]);
      end
    end else begin
      for (i = 0; i < `LFCB_NUM_REGS; i = i + 1) begin
        coef_q[i] <= coef_d[i];
      end
    end
  end

  // read data: a read in the same cycle as a write returns the old
  // byte, because the store only changes at the end of that cycle
  always @* begin
    rdata_d = `LFCB_RDATA_IDLE;
    if (rd_hit) begin
      rdata_d = coef_q[idx];
    end
  end

  // answer pulse for any access that lands in the bank; unmapped
  // accesses get none, so a master can tell a miss from a hit
  always @* begin
    ack_d = rd_hit | wr_hit;
  end

  // answer flops: data and pulse stand for exactly one cycle
  always @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= `LFCB_RDATA_IDLE;
      ack_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
    end
  end

  // read data and answer pulse come straight from flops
  assign reg_rdata = rdata_q;
  assign reg_ack   = ack_q;

  // named byte views, high byte at the lower address of each pair
  assign den2_hi = coef_q[`LFCB_IDX_EFF_DEN2_HIGH];
  assign den2_lo = coef_q[`LFCB_IDX_EFF_DEN2_LOW];
  assign den4_hi = coef_q[`LFCB_IDX_EFF_DEN4_HIGH];
  assign den4_lo = coef_q[`LFCB_IDX_EFF_DEN4_LOW];
  assign den5_hi = coef_q[`LFCB_IDX_EFF_DEN5_HIGH];
  assign den5_lo = coef_q[`LFCB_IDX_EFF_DEN5_LOW];
  assign num0_hi = coef_q[`LFCB_IDX_DEEMPH_NUM0_HIGH];
  assign num0_lo = coef_q[`LFCB_IDX_DEEMPH_NUM0_LOW];
  assign num1_hi = coef_q[`LFCB_IDX_DEEMPH_NUM1_HIGH];
  assign num1_lo = coef_q[`LFCB_IDX_DEEMPH_NUM1_LOW];

  // coefficients to the filter datapath, two's complement
  assign coef_effects_denominator_two  = lfcb_join(den2_hi, den2_lo);
  assign coef_effects_denominator_four = lfcb_join(den4_hi, den4_lo);
  assign coef_effects_denominator_five = lfcb_join(den5_hi, den5_lo);
  assign coef_deemph_numerator_zero    = lfcb_join(num0_hi, num0_lo);
  assign coef_deemph_numerator_one     = lfcb_join(num1_hi, num1_lo);

endmodule
`default_nettype wire

// >>> lfcb_coeff_bank_test.sv
`timescale 1ns/1ps
`default_nettype none
module lfcb_coeff_bank_test;
  logic        core_clk = 0;
  logic        rst = 1;
  logic [7:0]  reg_page = 8'h01;
  logic [6:0]  reg_addr = 7'h00;
  logic        reg_wr = 0;
  logic        reg_rd = 0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_sel, reg_ack;
  logic [7:0]  reg_rdata;
  logic [15:0] c2, c4, c5, m0, m1;
  int          error_cnt = 0, n_compared = 0, cyc = 0;
  // rows: address, reset byte read back, byte then written and read
  logic [22:0] rows [10] = '{23'h0f847b, 23'h10ee11, 23'h117d82,
                             23'h12837c, 23'h13847b, 23'h14ee11,
                             23'h1539c6, 23'h1655aa, 23'h17f30c,
                             23'h182dd2};
  lfcb_coeff_bank dut (.core_clk, .rst, .reg_page, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_sel, .reg_rdata, .reg_ack,
    .coef_effects_denominator_two(c2), .coef_effects_denominator_four(c4),
    .coef_effects_denominator_five(c5), .coef_deemph_numerator_zero(m0),
    .coef_deemph_numerator_one(m1));
  always #10 core_clk = ~core_clk;
  // one strobe cycle; answer sampled just after the edge that shows it
  task acc(input logic w, input logic [7:0] p, input logic [6:0] a,
           input logic [7:0] d);
    @(posedge core_clk);
    #1;
    {reg_page, reg_addr, reg_wr, reg_rd, reg_wdata} = {p, a, w, !w, d};
    @(posedge core_clk);
    #1;
    {reg_wr, reg_rd} = 2'b00;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h want %h", $time, g, e);
      error_cnt++;
    end
  endtask
  task stop_test;
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard, far above the roughly 80 cycles needed
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      stop_test;
    end
  end
  initial begin
    repeat (12) @(posedge core_clk);
    #1;
    rst = 0;
    chk(c2, 16'h84ee);
    chk(c4, 16'h7d83);
    chk(c5, 16'h84ee);
    chk(m0, 16'h3955);
    chk(m1, 16'hf32d);
    for (int i = 0; i < 10; i++) begin
      acc(0, 8'h01, rows[i][22:16], 8'h00);
      chk({7'h00, reg_ack, reg_rdata}, {8'h01, rows[i][15:8]});
      acc(1, 8'h01, rows[i][22:16], rows[i][7:0]);
      acc(0, 8'h01, rows[i][22:16], 8'h00);
      chk({7'h00, reg_ack, reg_rdata}, {8'h01, rows[i][7:0]});
    end
    chk(c2, 16'h7b11);
    chk(c4, 16'h827c);
    chk(c5, 16'h7b11);
    chk(m0, 16'hc6aa);
    chk(m1, 16'h0cd2);
    acc(1, 8'h01, 7'h0f, 8'h12);
    chk(c2, 16'h1211);
    acc(1, 8'h01, 7'h19, 8'h55);
    chk({14'h0, reg_sel, reg_ack}, 16'h0000);
    acc(1, 8'h02, 7'h0f, 8'h00);
    chk({reg_ack, c2[14:0]}, 16'h1211);
    rst = 1;
    @(posedge core_clk);
    #1;
    rst = 0;
    chk(c2, 16'h84ee);
    chk(m1, 16'hf32d);
    // read and write of one byte in one cycle: old byte comes back
    @(posedge core_clk);
    #1;
    {reg_page, reg_addr, reg_wdata} = {8'h01, 7'h0f, 8'h5a};
    {reg_wr, reg_rd} = 2'b11;
    @(posedge core_clk);
    #1;
    {reg_wr, reg_rd} = 2'b00;
    chk({7'h00, reg_ack, reg_rdata}, 16'h0184);
    chk(c2, 16'h5aee);
    stop_test;
  end
endmodule
`default_nettype wire

// >>> lfcb_defs.vh
`ifndef LFCB_DEFS_VH
`define LFCB_DEFS_VH

// control register page that holds the bank
`define LFCB_PAGE                  8'h01

// register offsets within the page, high byte at the lower address
`define LFCB_OFS_EFF_DEN2_HIGH     7'h0f
`define LFCB_OFS_EFF_DEN2_LOW      7'h10
`define LFCB_OFS_EFF_DEN4_HIGH     7'h11
`define LFCB_OFS_EFF_DEN4_LOW      7'h12
`define LFCB_OFS_EFF_DEN5_HIGH     7'h13
`define LFCB_OFS_EFF_DEN5_LOW      7'h14
`define LFCB_OFS_DEEMPH_NUM0_HIGH  7'h15
`define LFCB_OFS_DEEMPH_NUM0_LOW   7'h16
`define LFCB_OFS_DEEMPH_NUM1_HIGH  7'h17
`define LFCB_OFS_DEEMPH_NUM1_LOW   7'h18

// first and last offset of the bank
`define LFCB_OFS_FIRST             `LFCB_OFS_EFF_DEN2_HIGH
`define LFCB_OFS_LAST              `LFCB_OFS_DEEMPH_NUM1_LOW

// reset values
`define LFCB_RST_EFF_DEN2_HIGH     8'h84
`define LFCB_RST_EFF_DEN2_LOW      8'hee
`define LFCB_RST_EFF_DEN4_HIGH     8'h7d
`define LFCB_RST_EFF_DEN4_LOW      8'h83
`define LFCB_RST_EFF_DEN5_HIGH     8'h84
`define LFCB_RST_EFF_DEN5_LOW      8'hee
`define LFCB_RST_DEEMPH_NUM0_HIGH  8'h39
`define LFCB_RST_DEEMPH_NUM0_LOW   8'h55
`define LFCB_RST_DEEMPH_NUM1_HIGH  8'hf3
`define LFCB_RST_DEEMPH_NUM1_LOW   8'h2d

// bank geometry
`define LFCB_NUM_REGS              10
`define LFCB_IDX_W                 4
`define LFCB_REG_W                 8
`define LFCB_COEF_W                16

// slot of each register inside the byte store
`define LFCB_IDX_EFF_DEN2_HIGH     4'h0
`define LFCB_IDX_EFF_DEN2_LOW      4'h1
`define LFCB_IDX_EFF_DEN4_HIGH     4'h2
`define LFCB_IDX_EFF_DEN4_LOW      4'h3
`define LFCB_IDX_EFF_DEN5_HIGH     4'h4
`define LFCB_IDX_EFF_DEN5_LOW      4'h5
`define LFCB_IDX_DEEMPH_NUM0_HIGH  4'h6
`define LFCB_IDX_DEEMPH_NUM0_LOW   4'h7
`define LFCB_IDX_DEEMPH_NUM1_HIGH  4'h8
`define LFCB_IDX_DEEMPH_NUM1_LOW   4'h9

// read data shown while no read is answered
`define LFCB_RDATA_IDLE            8'h00

`endif

// >>> lfcb_props.sv
`timescale 1ns/1ps
`default_nettype none
module lfcb_props (
  input wire logic        core_clk,  // clock
  input wire logic        rst,       // reset
  input wire logic [7:0]  reg_page,  // page
  input wire logic [6:0]  reg_addr,  // address
  input wire logic        reg_wr,    // write
  input wire logic        reg_rd,    // read
  input wire logic [7:0]  reg_wdata, // data in
  input wire logic        reg_sel,   // in bank
  input wire logic [7:0]  reg_rdata, // data out
  input wire logic        reg_ack,   // answer
  input wire logic [15:0] coef_effects_denominator_two,  // coefficient
  input wire logic [15:0] coef_effects_denominator_four, // coefficient
  input wire logic [15:0] coef_effects_denominator_five, // coefficient
  input wire logic [15:0] coef_deemph_numerator_zero,    // coefficient
  input wire logic [15:0] coef_deemph_numerator_one      // coefficient
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // a taken access; unmapped strobes must stay silent
  wire hit = (reg_wr | reg_rd) & reg_sel;
  wire hi = reg_sel & (reg_addr == 7'h0f);
  property p_sel;
    reg_sel == (reg_page == 8'h01 && reg_addr inside {[7'h0f:7'h18]});
  endproperty
  a_sel: assert property (p_sel) else $error("bad select");
  property p_ack; hit |=> reg_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_nak; !hit |=> !reg_ack; endproperty
  a_nak: assert property (p_nak) else $error("stray ack");
  property p_idle; !reg_ack |-> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_rst; $fell(rst) |->
    coef_effects_denominator_two == 16'h84ee &&
    coef_effects_denominator_four == 16'h7d83 &&
    coef_effects_denominator_five == 16'h84ee &&
    coef_deemph_numerator_zero == 16'h3955 &&
    coef_deemph_numerator_one == 16'hf32d;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset value");
  property p_wr; reg_wr && hi |=>
    coef_effects_denominator_two[15:8] == $past(reg_wdata); endproperty
  a_wr: assert property (p_wr) else $error("high not stored");
  property p_lo; reg_wr && reg_addr != 7'h10 |=>
    $stable(coef_effects_denominator_two[7:0]); endproperty
  a_lo: assert property (p_lo) else $error("low byte moved");
  property p_rd; reg_rd && hi |=>
    reg_rdata == $past(coef_effects_denominator_two[15:8]); endproperty
  a_rd: assert property (p_rd) else $error("bad read");
  c_wr: cover property (reg_wr && hi);
  c_rd: cover property (reg_rd && hi);
  c_out: cover property (reg_wr && !reg_sel);
endmodule
bind lfcb_coeff_bank lfcb_props u_props (.core_clk, .rst, .reg_page,
  .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_sel, .reg_rdata, .reg_ack,
  .coef_effects_denominator_two, .coef_effects_denominator_four,
  .coef_effects_denominator_five, .coef_deemph_numerator_zero,
  .coef_deemph_numerator_one);
`default_nettype wire
